//--- hdl/sfb_pkg.sv
// shared types and constants for the frame, bound, push, multiply and shift execution unit
package sfb_pkg;

  // ==========================================================================
  // operations handed over by decode
  typedef enum logic [3:0] {
    op_frame_release,
    op_bound_check,
    op_push_imm,
    op_signed_multiply_imm,
    op_shift_arith_left_imm,
    op_shift_logical_left_imm,
    op_shift_arith_right_imm,
    op_shift_logical_right_imm,
    op_rotate_left_imm,
    op_rotate_right_imm,
    op_rotate_carry_left_imm,
    op_rotate_carry_right_imm
  } sfb_op_t;

  // ==========================================================================
  // constants
  localparam logic [7:0] SFB_VEC_BOUNDS = 8'h05;
  localparam logic [7:0] SFB_VEC_INVALID_OP = 8'h06;
  localparam logic [7:0] SFB_COUNT_MASK = 8'h1f;
  localparam logic [15:0] SFB_WORD_BYTES = 16'h0002;
  localparam logic [15:0] SFB_LIMIT_HI_OFS = 16'h0002;
  localparam logic [15:0] SFB_WORD_RST = 16'h0000;
  localparam logic [4:0] SFB_COUNT_RST = 5'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    sfb_op_t op;
    logic wide;
    logic src_mem;
    logic limit_reg_form;
    logic [15:0] reg_val;
    logic [15:0] ea;
    logic [15:0] imm;
    logic carry_flag;
    logic [15:0] sp;
    logic [15:0] frame_base_pointer;
  } sfb_cmd_t;

  typedef struct packed {
    logic req;
    logic we;
    logic wide;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sfb_mem_t;

  typedef struct packed {
    logic [15:0] result;
    logic wr_reg;
    logic carry_flag;
    logic [15:0] sp;
    logic [15:0] frame_base_pointer;
    logic exc;
    logic [7:0] exc_vec;
  } sfb_res_t;

endpackage

//--- hdl/sfb_exec.sv
// execution unit for frame release, bound check, push immediate, immediate multiply and shifts
`timescale 1ns/1ns

// How it works
// - release: sp from frame base, then pop base
// - bound: signed compare, outside raises type 5
// - lower limit at ea, upper at ea+2
// - register-form limit raises invalid opcode instead
// - push immediate byte is sign extended
// - multiply: sign extend byte, keep low 16
// - multiplier from register or memory
// - shift count ANDed with 1fh
// - arithmetic left shift fills zeros
// - logical left equals arithmetic left
// - arithmetic right refills original sign
// - logical right treated as arithmetic right
// - rotate left: msb into lsb
// - rotate right: lsb into msb
// - rotate carry left: carry in, msb out
// - rotate carry right: carry in, lsb out
module sfb_exec (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // command from decode
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input sfb_pkg::sfb_cmd_t cmd_i,
  // memory port
  output sfb_pkg::sfb_mem_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // completion
  output logic done_o,
  output sfb_pkg::sfb_res_t res_o
);
  import sfb_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic [15:0] sext_imm(input logic [15:0] imm, input logic wide);
    sext_imm = wide ? imm : {{8{imm[7]}}, imm[7:0]};
  endfunction

  function automatic logic [4:0] masked_count(input logic [15:0] imm);
    logic [7:0] m;
    m = imm[7:0] & SFB_COUNT_MASK;
    masked_count = m[4:0];
  endfunction

  function automatic logic [15:0] mul_low(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    mul_low = p[15:0];
  endfunction

  function automatic logic is_shift(input sfb_op_t op);
    is_shift = (op != op_frame_release) && (op != op_bound_check) &&
               (op != op_push_imm) && (op != op_signed_multiply_imm);
  endfunction

  // one single-bit step; returns {carry, value}, value kept to operand width
  function automatic logic [16:0] step(input sfb_op_t op, input logic [15:0] v, input logic carry_in,
                                       input logic wide);
    logic msb;
    logic [15:0] r;
    logic c;
    msb = wide ? v[15] : v[7];
    r = v;
    c = carry_in;
    case (op)
      op_shift_arith_left_imm, op_shift_logical_left_imm: begin
        c = msb;
        r = {v[14:0], 1'b0};
      end
      op_shift_arith_right_imm, op_shift_logical_right_imm: begin
        c = v[0];
        r = wide ? {v[15], v[15:1]} : {8'h00, v[7], v[7:1]};
      end
      op_rotate_left_imm: begin
        c = msb;
        r = wide ? {v[14:0], v[15]} : {8'h00, v[6:0], v[7]};
      end
      op_rotate_right_imm: begin
        c = v[0];
        r = wide ? {v[0], v[15:1]} : {8'h00, v[0], v[7:1]};
      end
      op_rotate_carry_left_imm: begin
        c = msb;
        r = wide ? {v[14:0], carry_in} : {8'h00, v[6:0], carry_in};
      end
      op_rotate_carry_right_imm: begin
        c = v[0];
        r = wide ? {carry_in, v[15:1]} : {8'h00, carry_in, v[7:1]};
      end
      default: begin
        c = carry_in;
        r = v;
      end
    endcase
    step = {c, wide ? r : {8'h00, r[7:0]}};
  endfunction

  // ==========================================================================
  // state
  typedef enum logic [2:0] {st_idle, st_read_a, st_read_b, st_shift, st_write, st_done} sfb_state_t;

  sfb_state_t state_r;
  sfb_state_t state_nxt;
  sfb_cmd_t cmd_r;
  sfb_mem_t mem_r;
  logic [15:0] val_r;
  logic [15:0] lim_lo_r;
  logic [15:0] result_r;
  logic [15:0] sp_r;
  logic [15:0] fbp_r;
  logic [4:0] cnt_r;
  logic carry_r;
  logic exc_r;
  logic [7:0] vec_r;
  logic wr_reg_r;
  logic accept;
  logic [16:0] step_out;

  assign accept = cmd_valid_i && (state_r == st_idle);
  assign cmd_ready_o = (state_r == st_idle);
  assign done_o = (state_r == st_done);
  assign mem_o = mem_r;
  assign step_out = step(cmd_r.op, val_r, carry_r, cmd_r.wide);
  assign res_o = '{result: result_r, wr_reg: wr_reg_r, carry_flag: carry_r, sp: sp_r,
                   frame_base_pointer: fbp_r, exc: exc_r, exc_vec: vec_r};

  // ==========================================================================
  // sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_idle: begin
        if (cmd_valid_i) begin
          case (cmd_i.op)
            op_frame_release: state_nxt = st_read_a;
            op_bound_check: state_nxt = cmd_i.limit_reg_form ? st_done : st_read_a;
            op_push_imm: state_nxt = st_write;
            op_signed_multiply_imm: state_nxt = cmd_i.src_mem ? st_read_a : st_done;
            default: state_nxt = cmd_i.src_mem ? st_read_a : st_shift;
          endcase
        end
      end
      st_read_a: begin
        if (mem_ack_i) begin
          case (cmd_r.op)
            op_bound_check: state_nxt = st_read_b;
            op_frame_release, op_signed_multiply_imm: state_nxt = st_done;
            default: state_nxt = st_shift;
          endcase
        end
      end
      st_read_b: if (mem_ack_i) state_nxt = st_done;
      st_shift: if (cnt_r == SFB_COUNT_RST) state_nxt = cmd_r.src_mem ? st_write : st_done;
      st_write: if (mem_ack_i) state_nxt = st_done;
      st_done: state_nxt = st_idle;
      default: state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // memory port
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mem_r <= '0;
    end else begin
      case (state_r)
        st_idle: begin
          if (cmd_valid_i) begin
            case (cmd_i.op)
              op_frame_release: mem_r <= '{req: 1'b1, we: 1'b0, wide: 1'b1,
                                          addr: cmd_i.frame_base_pointer, wdata: SFB_WORD_RST};
              op_bound_check: mem_r <= '{req: !cmd_i.limit_reg_form, we: 1'b0, wide: 1'b1,
                                        addr: cmd_i.ea, wdata: SFB_WORD_RST};
              op_push_imm: mem_r <= '{req: 1'b1, we: 1'b1, wide: 1'b1,
                                     addr: cmd_i.sp - SFB_WORD_BYTES, wdata: sext_imm(cmd_i.imm, cmd_i.wide)};
              default: mem_r <= '{req: cmd_i.src_mem, we: 1'b0, wide: cmd_i.wide,
                                 addr: cmd_i.ea, wdata: SFB_WORD_RST};
            endcase
          end
        end
        st_read_a: begin
          if (mem_ack_i) begin
            if (cmd_r.op == op_bound_check) begin
              mem_r.addr <= cmd_r.ea + SFB_LIMIT_HI_OFS;
            end else begin
              mem_r.req <= 1'b0;
            end
          end
        end
        st_shift: begin
          // memory destinations are written back only once the last step is done
          if (cnt_r == SFB_COUNT_RST && cmd_r.src_mem) begin
            mem_r <= '{req: 1'b1, we: 1'b1, wide: cmd_r.wide, addr: cmd_r.ea, wdata: val_r};
          end
        end
        default: if (mem_ack_i) mem_r.req <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // datapath
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cmd_r <= '0;
      val_r <= SFB_WORD_RST;
      lim_lo_r <= SFB_WORD_RST;
      result_r <= SFB_WORD_RST;
      sp_r <= SFB_WORD_RST;
      fbp_r <= SFB_WORD_RST;
      cnt_r <= SFB_COUNT_RST;
      carry_r <= 1'b0;
      exc_r <= 1'b0;
      vec_r <= 8'h00;
      wr_reg_r <= 1'b0;
    end else begin
      case (state_r)
        st_idle: begin
          if (cmd_valid_i) begin
            cmd_r <= cmd_i;
            carry_r <= cmd_i.carry_flag;
            fbp_r <= cmd_i.frame_base_pointer;
            cnt_r <= masked_count(cmd_i.imm);
            val_r <= cmd_i.wide ? cmd_i.reg_val : {8'h00, cmd_i.reg_val[7:0]};
            exc_r <= 1'b0;
            vec_r <= 8'h00;
            wr_reg_r <= (cmd_i.op == op_signed_multiply_imm) || (is_shift(cmd_i.op) && !cmd_i.src_mem);
            result_r <= mul_low(cmd_i.reg_val, sext_imm(cmd_i.imm, cmd_i.wide));
            case (cmd_i.op)
              op_frame_release: sp_r <= cmd_i.frame_base_pointer;
              op_push_imm: sp_r <= cmd_i.sp - SFB_WORD_BYTES;
              default: sp_r <= cmd_i.sp;
            endcase
            if (cmd_i.op == op_bound_check && cmd_i.limit_reg_form) begin
              exc_r <= 1'b1;
              vec_r <= SFB_VEC_INVALID_OP;
            end
          end
        end
        st_read_a: begin
          if (mem_ack_i) begin
            case (cmd_r.op)
              op_frame_release: begin
                fbp_r <= mem_rdata_i;
                sp_r <= sp_r + SFB_WORD_BYTES;
              end
              op_bound_check: lim_lo_r <= mem_rdata_i;
              op_signed_multiply_imm: result_r <= mul_low(mem_rdata_i, sext_imm(cmd_r.imm, cmd_r.wide));
              default: val_r <= cmd_r.wide ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
            endcase
          end
        end
        st_read_b: begin
          if (mem_ack_i) begin
            // lower limit first, upper limit second; both signed
            exc_r <= ($signed(cmd_r.reg_val) < $signed(lim_lo_r)) ||
                     ($signed(cmd_r.reg_val) > $signed(mem_rdata_i));
            vec_r <= SFB_VEC_BOUNDS;
          end
        end
        st_shift: begin
          // one bit per cycle: at most 31 steps, so a shift never stalls long
          if (cnt_r != SFB_COUNT_RST) begin
            {carry_r, val_r} <= step_out;
            cnt_r <= cnt_r - 5'h01;
          end else begin
            result_r <= val_r;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_accept_bound_reg;
    accept && cmd_i.op == op_bound_check && cmd_i.limit_reg_form;
  endsequence

  sequence s_accept_shift;
    accept && is_shift(cmd_i.op);
  endsequence

  property p_release_pop;
    (state_r == st_read_a && cmd_r.op == op_frame_release) |-> mem_o.req && !mem_o.we && mem_o.addr == sp_r;
  endproperty
  a_release_pop: assert property (p_release_pop) else $error("release pop not at frame base");

  property p_bound_vec;
    (done_o && cmd_r.op == op_bound_check && !cmd_r.limit_reg_form && res_o.exc) |->
      res_o.exc_vec == SFB_VEC_BOUNDS;
  endproperty
  a_bound_vec: assert property (p_bound_vec) else $error("bound exception vector wrong");

  property p_bound_upper_addr;
    (state_r == st_read_b) |-> mem_o.addr == cmd_r.ea + SFB_LIMIT_HI_OFS && !mem_o.we;
  endproperty
  a_bound_upper_addr: assert property (p_bound_upper_addr) else $error("upper limit address wrong");

  property p_bound_reg_form;
    s_accept_bound_reg |=> done_o && res_o.exc && res_o.exc_vec == SFB_VEC_INVALID_OP && !mem_o.req;
  endproperty
  a_bound_reg_form: assert property (p_bound_reg_form) else $error("register limit not refused");

  property p_push_data;
    (state_r == st_write && cmd_r.op == op_push_imm) |->
      mem_o.wdata == sext_imm(cmd_r.imm, cmd_r.wide) && mem_o.addr == cmd_r.sp - SFB_WORD_BYTES;
  endproperty
  a_push_data: assert property (p_push_data) else $error("push data or address wrong");

  property p_count_mask;
    s_accept_shift |=> cnt_r == masked_count(cmd_r.imm);
  endproperty
  a_count_mask: assert property (p_count_mask) else $error("shift count not masked");

  property p_count_down;
    (state_r == st_shift && cnt_r != SFB_COUNT_RST) |=> cnt_r == $past(cnt_r) - 5'h01;
  endproperty
  a_count_down: assert property (p_count_down) else $error("shift count not stepping");

  property p_rotate_left_word;
    (state_r == st_shift && cnt_r != SFB_COUNT_RST && cmd_r.op == op_rotate_left_imm && cmd_r.wide) |=>
      val_r == {$past(val_r[14:0]), $past(val_r[15])};
  endproperty
  a_rotate_left_word: assert property (p_rotate_left_word) else $error("rotate left step wrong");

  property p_rotate_carry_left;
    (state_r == st_shift && cnt_r != SFB_COUNT_RST && cmd_r.op == op_rotate_carry_left_imm && !cmd_r.wide) |=>
      carry_r == $past(val_r[7]) && val_r[0] == $past(carry_r);
  endproperty
  a_rotate_carry_left: assert property (p_rotate_carry_left) else $error("rotate through carry left wrong");

endmodule

//--- tb/sfb_mem_model.sv
// memory partner for the execution unit: word array with a programmable acknowledge delay
`timescale 1ns/1ns
module sfb_mem_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // access from the unit
  input sfb_pkg::sfb_mem_t mem_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  import sfb_pkg::*;
  logic [15:0] mem [0:255];
  logic [3:0] wait_r;
  logic [15:0] last_r;
  // ==========================================================================
  // answer
  assign ack_o = mem_i.req && (wait_r == delay_i);
  // off the acknowledge the bus is not held: show the inverse of the last word
  assign rdata_o = ack_o ? mem[mem_i.addr[8:1]] : ~last_r;
  always @(posedge clock_i) begin
    if (reset_i) begin
      wait_r <= 4'h0;
      last_r <= 16'h0000;
    end else if (ack_o) begin
      wait_r <= 4'h0;
      last_r <= rdata_o;
      if (mem_i.we && mem_i.wide) begin
        mem[mem_i.addr[8:1]] <= mem_i.wdata;
      end else if (mem_i.we) begin
        mem[mem_i.addr[8:1]][7:0] <= mem_i.wdata[7:0];
      end
    end else if (mem_i.req) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

//--- tb/test_stack_frame_bound_shift_exec.sv
// self-checking bench for the execution unit
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module test_stack_frame_bound_shift_exec;
  import sfb_pkg::*;
  logic clock_i, reset_i, cmd_valid_i, cmd_ready_o, mem_ack_i, done_o;
  logic [15:0] mem_rdata_i;
  logic [3:0] delay;
  sfb_cmd_t cmd_i, c;
  sfb_mem_t mem_o;
  sfb_res_t res_o;
  int err_count = 0;
  int n_checks = 0;
  sfb_exec DUT (.clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_i(cmd_i), .mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .done_o(done_o), .res_o(res_o));
  sfb_mem_model u_mem (.clock_i(clock_i), .reset_i(reset_i), .mem_i(mem_o), .delay_i(delay),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  // ==========================================================================
  // shared tasks
  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // offer one command, hold it until taken, then wait for completion
  task automatic run(input sfb_cmd_t cc);
    int n;
    cmd_i <= cc;
    cmd_valid_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 100);
    cmd_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (done_o !== 1'b1 && n < 200);
    `CHK(done_o, 1'b1, "no completion")
  endtask
  // reference for one shift or rotate, stepped bit by bit
  function automatic logic [16:0] ref_sh(sfb_op_t op, logic w, logic [15:0] v, logic [7:0] n, logic cy);
    logic [15:0] x, hb;
    logic m;
    int k;
    hb = w ? 16'h8000 : 16'h0080;
    x = w ? v : {8'h00, v[7:0]};
    for (k = 0; k < int'(n & SFB_COUNT_MASK); k++) begin
      m = (x & hb) != 16'h0000;
      case (op)
        op_shift_arith_left_imm, op_shift_logical_left_imm: begin cy = m; x = x << 1; end
        op_shift_arith_right_imm, op_shift_logical_right_imm: begin cy = x[0]; x = (x >> 1) | (m ? hb : 16'h0); end
        op_rotate_left_imm: begin cy = m; x = (x << 1) | {15'h0, m}; end
        op_rotate_right_imm: begin cy = x[0]; x = (x >> 1) | (x[0] ? hb : 16'h0); end
        op_rotate_carry_left_imm: begin x = (x << 1) | {15'h0, cy}; cy = m; end
        default: begin m = x[0]; x = (x >> 1) | (cy ? hb : 16'h0); cy = m; end
      endcase
      if (!w) x[15:8] = 8'h00;
    end
    return {cy, x};
  endfunction
  // ==========================================================================
  // scenarios
  task automatic t_release();
    delay = 4'h0;
    u_mem.mem[8'h20] = 16'h1234;
    c = '0; c.op = op_frame_release; c.sp = 16'h0010; c.frame_base_pointer = 16'h0040;
    run(c);
    `CHK({res_o.exc, res_o.sp}, {1'b0, 16'h0042}, "release stack pointer")
    `CHK(res_o.frame_base_pointer, 16'h1234, "release popped base")
  endtask
  task automatic t_bound();
    logic [15:0] v [5] = '{16'hfffb, 16'h0007, 16'hfffa, 16'h0008, 16'h8000};
    delay = 4'h3;
    u_mem.mem[8'h08] = 16'hfffb;
    u_mem.mem[8'h09] = 16'h0007;
    for (int i = 0; i < 5; i++) begin
      c = '0; c.op = op_bound_check; c.wide = 1'b1; c.src_mem = 1'b1; c.ea = 16'h0010; c.reg_val = v[i];
      run(c);
      `CHK(res_o.exc, (i >= 2), "bound decision")
      if (i >= 2) `CHK(res_o.exc_vec, SFB_VEC_BOUNDS, "bound vector")
    end
    c.limit_reg_form = 1'b1;
    run(c);
    `CHK({res_o.exc, res_o.exc_vec}, {1'b1, SFB_VEC_INVALID_OP}, "register limit")
  endtask
  task automatic t_push();
    delay = 4'h1;
    c = '0; c.op = op_push_imm; c.imm = 16'h0080; c.sp = 16'h0100;
    run(c);
    `CHK({res_o.wr_reg, res_o.sp}, {1'b0, 16'h00fe}, "push byte sp")
    `CHK(u_mem.mem[8'h7f], 16'hff80, "push byte sign extended")
    c.wide = 1'b1; c.imm = 16'h1234; c.sp = 16'h00fe;
    run(c);
    `CHK(u_mem.mem[8'h7e], 16'h1234, "push word")
  endtask
  task automatic t_mul();
    delay = 4'h2;
    c = '0; c.op = op_signed_multiply_imm; c.imm = 16'h00fe; c.reg_val = 16'h0003;
    run(c);
    `CHK({res_o.wr_reg, res_o.result}, {1'b1, 16'hfffa}, "multiply byte imm")
    u_mem.mem[8'h18] = 16'h0100;
    c.wide = 1'b1; c.src_mem = 1'b1; c.ea = 16'h0030; c.imm = 16'h0123;
    run(c);
    `CHK({res_o.wr_reg, res_o.result}, {1'b1, 16'h2300}, "multiply memory source")
  endtask
  task automatic t_shift();
    logic [7:0] cnt [5] = '{8'h00, 8'h01, 8'h05, 8'h1f, 8'h23};
    logic [16:0] e;
    delay = 4'h0;
    for (int o = 4; o < 12; o++) begin
      for (int k = 0; k < 10; k++) begin
        c = '0; c.op = sfb_op_t'(o); c.wide = k[0]; c.imm = {8'h00, cnt[k / 2]};
        c.reg_val = 16'h8d35; c.carry_flag = 1'b1;
        e = ref_sh(c.op, c.wide, c.reg_val, cnt[k / 2], 1'b1);
        run(c);
        `CHK({res_o.wr_reg, res_o.carry_flag, res_o.result}, {1'b1, e}, "shift or rotate")
      end
    end
    u_mem.mem[8'h28] = 16'h00c3;
    c = '0; c.op = op_rotate_carry_right_imm; c.src_mem = 1'b1; c.ea = 16'h0050; c.imm = 16'h0009;
    e = ref_sh(c.op, 1'b0, 16'h00c3, 8'h09, 1'b0);
    run(c);
    `CHK({res_o.wr_reg, res_o.carry_flag, u_mem.mem[8'h28][7:0]}, {1'b0, e[16], e[7:0]}, "byte memory rotate")
  endtask
  // ==========================================================================
  // clock, reset, sequence and watchdog
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    reset_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    delay = 4'h0;
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    t_release();
    t_bound();
    t_push();
    t_mul();
    t_shift();
    end_of_test();
  end
  // about 100 commands of at most some 40 cycles each fit well inside this span
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule
